//--- shared/dts_pkg.sv
// Package for the drive enable interlock and safe torque off monitor.
// Assumes a 40 MHz system clock and an APB master that owns the register file.
package dts_pkg;
   // Clock and timing.
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned TICK_MS         = 1;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TICK_W          = 16;
   localparam int unsigned DISC_W          = 12;
   localparam logic [11:0] DISC_MIN_MS     = 12'h032;
   localparam logic [11:0] DISC_MAX_MS     = 12'hBB8;
   // Bus voltage window in millivolts and the 90 percent margin.
   localparam int unsigned VOLT_W          = 17;
   localparam logic [16:0] VBUS_MIN_MV     = 17'h04A38;
   localparam logic [16:0] VBUS_MAX_MV     = 17'h17318;
   localparam int unsigned OV_PCT          = 90;
   localparam int unsigned PCT_FULL        = 100;
   // Position error window in encoder counts.
   localparam int unsigned POS_W           = 32;
   localparam logic [31:0] POS_ERR_LIM     = 32'h0000_1000;
   // Register byte offsets.
   localparam logic [7:0]  CTRL_OFS        = 8'h00;
   localparam logic [7:0]  DISC_OFS        = 8'h04;
   localparam logic [7:0]  OVTH_OFS        = 8'h08;
   localparam logic [7:0]  STAT_OFS        = 8'h0C;
   localparam logic [7:0]  PROF_OFS        = 8'h10;
   // Control register fields.
   localparam int unsigned CTRL_EN_REQ     = 0;
   localparam int unsigned CTRL_CMD_MODE   = 1;
   localparam int unsigned CTRL_PRESET     = 2;
   localparam int unsigned CTRL_ESTOP_CFG  = 3;
   localparam int unsigned CTRL_SAFETY_OPT = 4;
   localparam int unsigned CTRL_MOVE_REQ   = 5;
   localparam int unsigned CTRL_W          = 6;
   localparam logic [5:0]  CTRL_RESET      = 6'h10;
   // Status register fields.
   localparam int unsigned ST_ENABLED      = 0;
   localparam int unsigned ST_DRV_FAULT    = 1;
   localparam int unsigned ST_IN_A         = 2;
   localparam int unsigned ST_IN_B         = 3;
   localparam int unsigned ST_TORQUE_OFF   = 4;
   localparam int unsigned ST_FAULT_LATCH  = 5;
   localparam int unsigned ST_MOVE_OK      = 6;
   localparam int unsigned ST_DISC_ERR     = 7;
   localparam int unsigned ST_CFG_BAD      = 8;

   // Health and plant conditions that arrive from the rest of the unit.
   typedef struct packed {
      logic config_error;
      logic health_ok;
      logic over_temp;
      logic over_current;
      logic encoder_ok;
      logic stage_active;
      logic estop_input;
   } dts_plant_s;

   // Status bits reported toward the network input data.
   typedef struct packed {
      logic safety_fault_latched;
      logic safety_torque_removed;
      logic safety_input_b_state;
      logic safety_input_a_state;
      logic driver_fault;
      logic drive_enabled_flag;
   } dts_status_s;
endpackage : dts_pkg

//--- core/dts_monitor.sv
// Drive enable interlock and safe torque off monitor with an APB register file.
// Assumes safety inputs and plant flags arrive asynchronously; APB is on CLK.
// Function
// - Enable only in command mode with no configuration error.
// - Enable only while the health flag reads one.
// - Block enable on over-temperature or over-current.
// - Bus voltage 19 to 95 V, and below 90 percent of a set threshold.
// - Configured emergency stop input active refuses enable.
// - Encoder must be healthy and supplying a valid position.
// - Position error under 4096 counts or preset flag; preset loads profile position.
// - With safety option, torque-removed and fault-latched bits must both be zero.
// - Either safety input inactive removes stage drive; software cannot override.
// - Discrete inputs 3 and 4 serve as the redundant safety inputs.
// - Discrepancy limit accepts 0 or 50 to 3000 milliseconds.
// - Inputs differing longer than the limit is a discrepancy failure.
// - One input changing twice within the limit is a discrepancy failure.
// - A zero limit disables both discrepancy checks.
// - Drive-enabled bit is one exactly while the drive_enabled_flag.
// - Driver-fault bit follows over-temperature, over-current or inactive safety input.
// - While driver-fault is set, drive stays disabled and enable is rejected.
// - One status bit per safety input, one when active.
// - Torque-removed bit sets on inactive input, clears only with both active.
// - Fault latch sets on inactive input with active stage, or discrepancy failure.
// - On fault latch, stage is commanded off and moves are rejected.
// - Fault latch clears only on power-up reset, never by host.
// - Active emergency stop forces an immediate stop and blocks moves.
`timescale 1ns/10ps
`default_nettype none
module dts_monitor #(
   parameter int unsigned TICK_CYCLES_P = dts_pkg::TICK_CYCLES
) (
   input  wire logic                         CLK,
   input  wire logic                         RST_B,
   input  wire logic                         PSEL,
   input  wire logic                         PENABLE,
   input  wire logic                         PWRITE,
   input  wire logic [7:0]                   PADDR,
   input  wire logic [31:0]                  PWDATA,
   output logic      [31:0]                  PRDATA,
   output logic                              PREADY,
   output logic                              PSLVERR,
   input  wire logic                         SAFETY_INPUT_A,
   input  wire logic                         SAFETY_INPUT_B,
   input  wire dts_pkg::dts_plant_s          PLANT,
   input  wire logic [dts_pkg::VOLT_W-1:0]   VBUS_MV,
   input  wire logic [dts_pkg::POS_W-1:0]    ENC_POS,
   output logic                              STAGE_ENABLE,
   output logic                              PROFILE_LOAD,
   output logic                              IMMEDIATE_STOP,
   output logic                              MOVE_ALLOWED,
   output dts_pkg::dts_status_s              STATUS
);
   import dts_pkg::*;

   // Asynchronous inputs pass two flip-flops before any logic reads them.
   logic [1:0]          sa_sync, sb_sync;
   dts_plant_s          pl_s1, pl_s2;
   logic [VOLT_W-1:0]   vb_s1, vb_s2;
   logic [POS_W-1:0]    ep_s1, ep_s2;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         sa_sync <= 2'h0;
         sb_sync <= 2'h0;
         pl_s1   <= '0;
         pl_s2   <= '0;
         vb_s1   <= '0;
         vb_s2   <= '0;
         ep_s1   <= '0;
         ep_s2   <= '0;
      end else begin
         sa_sync <= {sa_sync[0], SAFETY_INPUT_A};
         sb_sync <= {sb_sync[0], SAFETY_INPUT_B};
         pl_s1   <= PLANT;
         pl_s2   <= pl_s1;
         vb_s1   <= VBUS_MV;
         vb_s2   <= vb_s1;
         ep_s1   <= ENC_POS;
         ep_s2   <= ep_s1;
      end
   end
   logic in_a, in_b;
   assign in_a = sa_sync[1];
   assign in_b = sb_sync[1];

   // Software registers.
   logic [CTRL_W-1:0]   ctrl;
   logic [DISC_W-1:0]   disc_lim;
   logic [VOLT_W-1:0]   ov_thresh;
   logic [POS_W-1:0]    profile_pos;
   logic                cfg_bad;
   logic                wr_acc;
   logic                rd_acc;
   assign wr_acc = PSEL && PENABLE && PWRITE;
   assign rd_acc = PSEL && PENABLE && !PWRITE;

   // Legal discrepancy limit: zero or inside the millisecond window.
   function automatic logic disc_legal(input logic [DISC_W-1:0] v);
      return (v == '0) || ((v >= DISC_MIN_MS) && (v <= DISC_MAX_MS));
   endfunction : disc_legal

   // Control writes; an illegal limit is refused and flagged as a configuration error.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl      <= CTRL_RESET;
         disc_lim  <= '0;
         ov_thresh <= '0;
         cfg_bad   <= 1'b0;
      end else if (wr_acc) begin
         unique case (PADDR)
            CTRL_OFS: ctrl <= PWDATA[CTRL_W-1:0];
            DISC_OFS: begin
               if (disc_legal(PWDATA[DISC_W-1:0]) && (PWDATA[31:DISC_W] == '0)) begin
                  disc_lim <= PWDATA[DISC_W-1:0];
                  cfg_bad  <= 1'b0;
               end else begin
                  cfg_bad  <= 1'b1;
               end
            end
            OVTH_OFS: ov_thresh <= PWDATA[VOLT_W-1:0];
            default:  ;
         endcase
      end
   end

   // Discrepancy timing on a millisecond tick.
   logic [TICK_W-1:0]   tick_cnt;
   logic                ms_tick;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         tick_cnt <= '0;
         ms_tick  <= 1'b0;
      end else if (tick_cnt == TICK_W'(TICK_CYCLES_P - 1)) begin
         tick_cnt <= '0;
         ms_tick  <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
         ms_tick  <= 1'b0;
      end
   end

   // Mismatch timer and per-input time since last change, saturating.
   logic                in_a_d, in_b_d;
   logic [DISC_W-1:0]   mis_ms, a_ms, b_ms;
   logic                disc_fail;
   logic                disc_on;
   assign disc_on = (disc_lim != '0);
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         // Match the synchroniser's reset level so no false change follows reset.
         in_a_d    <= 1'b0;
         in_b_d    <= 1'b0;
         mis_ms    <= '0;
         a_ms      <= '1;
         b_ms      <= '1;
         disc_fail <= 1'b0;
      end else begin
         in_a_d <= in_a;
         in_b_d <= in_b;
         if (in_a == in_b) mis_ms <= '0;
         else if (ms_tick && (mis_ms != '1)) mis_ms <= mis_ms + 1'b1;
         if (in_a != in_a_d) a_ms <= '0;
         else if (ms_tick && (a_ms != '1)) a_ms <= a_ms + 1'b1;
         if (in_b != in_b_d) b_ms <= '0;
         else if (ms_tick && (b_ms != '1)) b_ms <= b_ms + 1'b1;
         // Not held here; the fault latch below holds it.
         disc_fail <= disc_on && ((mis_ms > disc_lim)
                      || ((in_a != in_a_d) && (a_ms < disc_lim))
                      || ((in_b != in_b_d) && (b_ms < disc_lim)));
      end
   end

   // Interlock terms.
   logic                both_in;
   logic                drv_fault;
   logic                volt_ok;
   logic                pos_ok;
   logic                estop_act;
   logic                safety_ok;
   logic                permit;
   logic [POS_W-1:0]    pos_diff;
   logic [VOLT_W+6:0]   vb_scaled, th_scaled;
   logic                fault_latch;
   logic                torque_removed;
   assign both_in   = in_a && in_b;
   assign drv_fault = pl_s2.over_temp || pl_s2.over_current || !both_in;
   assign vb_scaled = (VOLT_W+7)'(vb_s2) * (VOLT_W+7)'(PCT_FULL);
   assign th_scaled = (VOLT_W+7)'(ov_thresh) * (VOLT_W+7)'(OV_PCT);
   assign volt_ok   = (vb_s2 >= VBUS_MIN_MV) && (vb_s2 <= VBUS_MAX_MV)
                      && ((ov_thresh == '0) || (vb_scaled < th_scaled));
   assign pos_diff  = ep_s2 - profile_pos;
   assign pos_ok    = ($signed(pos_diff) < $signed(POS_ERR_LIM))
                      && ($signed(pos_diff) > -$signed(POS_ERR_LIM));
   assign estop_act = ctrl[CTRL_ESTOP_CFG] && pl_s2.estop_input;
   assign safety_ok = !ctrl[CTRL_SAFETY_OPT] || (!torque_removed && !fault_latch);
   assign permit    = ctrl[CTRL_CMD_MODE] && !pl_s2.config_error && !cfg_bad
                      && pl_s2.health_ok
                      && !drv_fault
                      && volt_ok && !estop_act
                      && pl_s2.encoder_ok
                      && (pos_ok || ctrl[CTRL_PRESET]) && safety_ok && !fault_latch;

   // Stage drive: enables on request when permitted, drops at once when not.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         STAGE_ENABLE <= 1'b0;
         PROFILE_LOAD <= 1'b0;
      end else begin
         STAGE_ENABLE <= ctrl[CTRL_EN_REQ] && permit;
         PROFILE_LOAD <= ctrl[CTRL_EN_REQ] && permit && !STAGE_ENABLE
                         && ctrl[CTRL_PRESET];
      end
   end

   // Profile position: host writes, or a preset from the encoder at enable.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) profile_pos <= '0;
      else if (ctrl[CTRL_EN_REQ] && permit && !STAGE_ENABLE && ctrl[CTRL_PRESET])
         profile_pos <= ep_s2;
      else if (wr_acc && (PADDR == PROF_OFS)) profile_pos <= PWDATA;
   end

   // Safety status; the latch has no clear path except reset.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fault_latch    <= 1'b0;
         torque_removed <= 1'b0;
      end else begin
         if ((!both_in && pl_s2.stage_active) || disc_fail) fault_latch <= 1'b1;
         torque_removed <= !both_in;
      end
   end

   // Move gating and immediate stop.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         IMMEDIATE_STOP <= 1'b0;
         MOVE_ALLOWED   <= 1'b0;
      end else begin
         IMMEDIATE_STOP <= estop_act;
         MOVE_ALLOWED   <= ctrl[CTRL_MOVE_REQ] && !estop_act && !fault_latch;
      end
   end

   // Status output.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) STATUS <= '0;
      else begin
         STATUS.drive_enabled_flag    <= STAGE_ENABLE;
         STATUS.driver_fault          <= drv_fault;
         STATUS.safety_input_a_state  <= in_a;
         STATUS.safety_input_b_state  <= in_b;
         STATUS.safety_torque_removed <= torque_removed;
         STATUS.safety_fault_latched  <= fault_latch;
      end
   end

   // APB read side; zero wait states, unmapped addresses answer an error.
   logic mapped;
   assign mapped = (PADDR == CTRL_OFS) || (PADDR == DISC_OFS) || (PADDR == OVTH_OFS)
                   || (PADDR == STAT_OFS) || (PADDR == PROF_OFS);
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PRDATA  <= '0;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && (!mapped || (PWRITE && (PADDR == STAT_OFS)));
         PRDATA  <= '0;
         if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
               CTRL_OFS: PRDATA <= 32'(ctrl);
               DISC_OFS: PRDATA <= 32'(disc_lim);
               OVTH_OFS: PRDATA <= 32'(ov_thresh);
               STAT_OFS: begin
                  PRDATA[ST_ENABLED]     <= STAGE_ENABLE;
                  PRDATA[ST_DRV_FAULT]   <= drv_fault;
                  PRDATA[ST_IN_A]        <= in_a;
                  PRDATA[ST_IN_B]        <= in_b;
                  PRDATA[ST_TORQUE_OFF]  <= torque_removed;
                  PRDATA[ST_FAULT_LATCH] <= fault_latch;
                  PRDATA[ST_MOVE_OK]     <= MOVE_ALLOWED;
                  PRDATA[ST_DISC_ERR]    <= disc_fail;
                  PRDATA[ST_CFG_BAD]     <= cfg_bad;
               end
               PROF_OFS: PRDATA <= profile_pos;
               default:  PRDATA <= '0;
            endcase
         end
      end
   end
   logic unused_rd;
   assign unused_rd = rd_acc;

   // Checks beside the logic.
   stage_off_a: assert property (@(posedge CLK) disable iff (!RST_B)
      !both_in |=> !STAGE_ENABLE) else $error("Stage on with safety input low.");
   fault_block_a: assert property (@(posedge CLK) disable iff (!RST_B)
      drv_fault |=> !STAGE_ENABLE) else $error("Stage on during driver fault.");
   latch_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
      fault_latch |=> fault_latch) else $error("Fault latch cleared.");
   latch_set_a: assert property (@(posedge CLK) disable iff (!RST_B)
      disc_fail |=> fault_latch) else $error("Discrepancy did not latch.");
   no_disc_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (disc_lim == '0) |=> !disc_fail) else $error("Check ran with zero limit.");
   mode_gate_a: assert property (@(posedge CLK) disable iff (!RST_B)
      !ctrl[CTRL_CMD_MODE] |=> !STAGE_ENABLE) else $error("Stage on outside command mode.");
   estop_move_a: assert property (@(posedge CLK) disable iff (!RST_B)
      estop_act |=> (IMMEDIATE_STOP && !MOVE_ALLOWED)) else $error("Move during stop.");
   enab_flag_a: assert property (@(posedge CLK) disable iff (!RST_B)
      1'b1 |=> (STATUS.drive_enabled_flag == $past(STAGE_ENABLE)))
      else $error("Enabled flag wrong.");
   torque_bit_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (!in_a || !in_b) ##1 1'b1 |=> STATUS.safety_torque_removed)
      else $error("Torque removed bit not set.");
   limit_legal_a: assert property (@(posedge CLK) disable iff (!RST_B)
      disc_legal(disc_lim)) else $error("Illegal limit held.");
   enable_c: cover property (@(posedge CLK) disable iff (!RST_B) $rose(STAGE_ENABLE));
   latch_c:  cover property (@(posedge CLK) disable iff (!RST_B) $rose(fault_latch));
   disc_c:   cover property (@(posedge CLK) disable iff (!RST_B) disc_fail);
   preset_c: cover property (@(posedge CLK) disable iff (!RST_B) PROFILE_LOAD);
endmodule : dts_monitor
`default_nettype wire

//--- sim/dts_stage_model.sv
// Behavioural power stage and safety pin circuitry facing the monitor.
// Assumes the bench drives both safety pins and the welded-stage control.
`timescale 1ns/10ps
`default_nettype none
module dts_stage_model (
   input  wire logic stage_enable,
   input  wire logic safety_input_a,
   input  wire logic safety_input_b,
   input  wire logic stuck_active,
   output logic      stage_active
);
   // The pins cut the stage in hardware, so no lag is modelled here.
   // A welded stage stays active only when the bench asks for that failure.
   assign stage_active = stuck_active | (stage_enable & safety_input_a & safety_input_b);
endmodule : dts_stage_model
`default_nettype wire

//--- sim/test_drive_enable_safe_torque_monitor.sv
// Self-checking bench for the drive enable interlock and safe torque off monitor.
// Assumes dts_pkg and the stage model come first; the ms tick is cut to four cycles.
`timescale 1ns/10ps
`default_nettype none
module test_drive_enable_safe_torque_monitor;
   import dts_pkg::*;
   typedef struct packed {
      logic [5:0]  ctrl;
      logic [5:0]  pl;
      logic [16:0] vb;
      logic [31:0] ov;
      logic [31:0] enc;
      logic [1:0]  ex;
   } dts_row_s;
   localparam int MS = 4;
   logic        CLK = 1'b0;
   logic        RST_B = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat, pulses;
   logic        rerr, in_a = 1'b1, in_b = 1'b1, stuck = 1'b0, stage_act;
   logic        stage_en, prof_load, istop, move_ok;
   logic [5:0]  pl = 6'h12;
   logic [16:0] vbus = 17'h0BB80;
   logic [31:0] enc = 32'h0;
   dts_plant_s  plant;
   dts_status_s status;
   int          n_mismatch = 0, tests_run = 0, cycles = 0;
   dts_row_s    r;
   logic [31:0] dv [5] = '{32'h31, 32'h32, 32'hBB8, 32'hBB9, 32'h0};
   logic [31:0] dx [5] = '{32'h0, 32'h32, 32'hBB8, 32'hBB8, 32'h0};
   logic [4:0]  db = 5'b01001;
   // Each row: control, plant flags, bus mV, threshold, encoder, {enable, move}.
   dts_row_s    rows [21] = '{
      '{6'h33, 6'h12, 17'h0BB80, 32'h0, 32'h0, 2'h3},
      '{6'h31, 6'h12, 17'h0BB80, 32'h0, 32'h0, 2'h1},
      '{6'h33, 6'h32, 17'h0BB80, 32'h0, 32'h0, 2'h1},
      '{6'h33, 6'h02, 17'h0BB80, 32'h0, 32'h0, 2'h1},
      '{6'h33, 6'h1A, 17'h0BB80, 32'h0, 32'h0, 2'h1},
      '{6'h33, 6'h16, 17'h0BB80, 32'h0, 32'h0, 2'h1},
      '{6'h33, 6'h10, 17'h0BB80, 32'h0, 32'h0, 2'h1},
      '{6'h33, 6'h12, 17'h04A37, 32'h0, 32'h0, 2'h1},
      '{6'h33, 6'h12, 17'h04A38, 32'h0, 32'h0, 2'h3},
      '{6'h33, 6'h12, 17'h17318, 32'h0, 32'h0, 2'h3},
      '{6'h33, 6'h12, 17'h17319, 32'h0, 32'h0, 2'h1},
      '{6'h33, 6'h12, 17'h11940, 32'h13880, 32'h0, 2'h1},
      '{6'h33, 6'h12, 17'h1193F, 32'h13880, 32'h0, 2'h3},
      '{6'h33, 6'h12, 17'h0BB80, 32'h0, 32'h1000, 2'h1},
      '{6'h33, 6'h12, 17'h0BB80, 32'h0, 32'hFFF, 2'h3},
      '{6'h33, 6'h12, 17'h0BB80, 32'h0, 32'hFFFFF000, 2'h1},
      '{6'h33, 6'h12, 17'h0BB80, 32'h0, 32'hFFFFF001, 2'h3},
      '{6'h37, 6'h12, 17'h0BB80, 32'h0, 32'h1000, 2'h3},
      '{6'h3B, 6'h13, 17'h0BB80, 32'h0, 32'h0, 2'h0},
      '{6'h33, 6'h13, 17'h0BB80, 32'h0, 32'h0, 2'h3},
      '{6'h13, 6'h12, 17'h0BB80, 32'h0, 32'h0, 2'h2}};

   // The stage flag comes from the partner, the rest straight from the bench.
   assign plant = {pl[5:1], stage_act, pl[0]};

   dts_monitor #(.TICK_CYCLES_P(MS)) dts_monitor_inst (
      .CLK(CLK), .RST_B(RST_B), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SAFETY_INPUT_A(in_a), .SAFETY_INPUT_B(in_b), .PLANT(plant),
      .VBUS_MV(vbus), .ENC_POS(enc), .STAGE_ENABLE(stage_en), .PROFILE_LOAD(prof_load),
      .IMMEDIATE_STOP(istop), .MOVE_ALLOWED(move_ok), .STATUS(status));

   dts_stage_model dts_stage_model_inst (
      .stage_enable(stage_en), .safety_input_a(in_a), .safety_input_b(in_b),
      .stuck_active(stuck), .stage_active(stage_act));

   // Free running 40 MHz clock.
   always #12.5 CLK = ~CLK;

   // A hang is cut short well above the expected few thousand cycles.
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 10000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
   endtask : cyc

   // Word compare; the bit and status compares widen into it.
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic chb(input string what, input logic e, input logic g);
      chk(what, {31'h0, e}, {31'h0, g});
   endtask : chb

   task automatic chs(input logic [5:0] e);
      chk("status", {26'h0, e}, {26'h0, status});
   endtask : chs

   // One APB transfer; request held until pready is seen at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge CLK);
      penable <= 1'b1;
      do
         @(posedge CLK);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic pins(input logic a, input logic b);
      @(posedge CLK);
      in_a <= a;
      in_b <= b;
   endtask : pins

   task automatic do_reset();
      @(posedge CLK);
      RST_B <= 1'b0;
      cyc(10);
      RST_B <= 1'b1;
      cyc(2);
   endtask : do_reset

   // Main sequence: registers, the interlock table, then the safety cases.
   initial begin
      do_reset();
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl reset", 32'h10, rdat);
      apb(1'b0, 8'h14, 32'h0);
      chb("unmapped err", 1'b1, rerr);
      apb(1'b1, STAT_OFS, 32'h3F);
      chb("stat write err", 1'b1, rerr);
      foreach (dv[k]) begin
         apb(1'b1, DISC_OFS, dv[k]);
         apb(1'b0, DISC_OFS, 32'h0);
         chk("disc limit", dx[k], rdat);
         apb(1'b0, STAT_OFS, 32'h0);
         chb("cfg bad", db[k], rdat[ST_CFG_BAD]);
      end
      foreach (rows[k]) begin
         r = rows[k];
         apb(1'b1, CTRL_OFS, 32'h10);
         apb(1'b1, OVTH_OFS, r.ov);
         apb(1'b1, PROF_OFS, 32'h0);
         @(posedge CLK);
         pl   <= r.pl;
         vbus <= r.vb;
         enc  <= r.enc;
         cyc(5);
         apb(1'b1, CTRL_OFS, {26'h0, r.ctrl});
         cyc(5);
         chk("enable move", {30'h0, r.ex}, {30'h0, stage_en, move_ok});
         chb("enabled flag", r.ex[1], status.drive_enabled_flag);
         chb("driver fault", r.pl[3] | r.pl[2], status.driver_fault);
         chb("estop", r.ctrl[3] & r.pl[0], istop);
      end
      // Preset on enable gives exactly one load and the profile takes the encoder.
      apb(1'b1, CTRL_OFS, 32'h10);
      @(posedge CLK);
      enc <= 32'h0000_1388;
      cyc(5);
      apb(1'b1, CTRL_OFS, 32'h37);
      pulses = 32'h0;
      repeat (8) begin
         @(posedge CLK);
         pulses += {31'h0, prof_load};
      end
      chk("load pulses", 32'h1, pulses);
      apb(1'b0, PROF_OFS, 32'h0);
      chk("profile", 32'h1388, rdat);
      // Either pin low removes torque and no write brings it back.
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, CTRL_OFS, 32'h37);
         cyc(6);
         chb("enabled", 1'b1, stage_en);
         pins(k[0], !k[0]);
         cyc(4);
         chb("stage off", 1'b0, stage_en);
         cyc(2);
         chs({1'b0, 1'b1, !k[0], k[0], 1'b1, 1'b0});
         apb(1'b1, CTRL_OFS, 32'h37);
         cyc(4);
         chb("no override", 1'b0, stage_en);
         pins(1'b1, 1'b1);
         cyc(6);
         chb("torque back", 1'b0, status.safety_torque_removed);
         chb("fault gone", 1'b0, status.driver_fault);
         chb("no latch", 1'b0, status.safety_fault_latched);
      end
      // With a 50 ms limit a slow cycle is fine and a fast one fails.
      apb(1'b1, DISC_OFS, 32'h32);
      cyc(60 * MS);
      pins(1'b0, 1'b0);
      cyc(60 * MS);
      pins(1'b1, 1'b1);
      cyc(60 * MS);
      chb("slow cycle", 1'b0, status.safety_fault_latched);
      pins(1'b0, 1'b0);
      cyc(10 * MS);
      pins(1'b1, 1'b1);
      cyc(8);
      chb("fast cycle", 1'b1, status.safety_fault_latched);
      apb(1'b1, CTRL_OFS, 32'h0);
      apb(1'b1, CTRL_OFS, 32'h37);
      cyc(6);
      chb("latched stage", 1'b0, stage_en);
      chb("latched move", 1'b0, move_ok);
      chb("host no clear", 1'b1, status.safety_fault_latched);
      do_reset();
      chb("reset clears", 1'b0, status.safety_fault_latched);
      // A lasting mismatch fails only after the limit has run out.
      apb(1'b1, DISC_OFS, 32'h32);
      cyc(60 * MS);
      pins(1'b0, 1'b1);
      cyc(40 * MS);
      chb("short mismatch", 1'b0, status.safety_fault_latched);
      cyc(20 * MS);
      chb("long mismatch", 1'b1, status.safety_fault_latched);
      pins(1'b1, 1'b1);
      do_reset();
      // A welded stage seen with a pin low latches the fault.
      @(posedge CLK);
      stuck <= 1'b1;
      cyc(4);
      pins(1'b1, 1'b0);
      cyc(6);
      chb("welded stage", 1'b1, status.safety_fault_latched);
      chb("welded drive", 1'b0, stage_en);
      end_of_test();
   end
endmodule : test_drive_enable_safe_torque_monitor
`default_nettype wire
